// [core/gsr_pkg.sv]
package gsr_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_PIN01_ROUTE   = 8'h23; // Pin 0 and pin 1 route codes
  localparam logic [7:0] IDX_PIN2_ROUTE    = 8'h24; // Pin 2 route code
  localparam logic [7:0] IDX_INPUT_LEVELS  = 8'h25; // Sampled pin levels
  localparam logic [7:0] IDX_STAMP_SYNC    = 8'h26; // Stamp and sync control
  localparam logic [7:0] IDX_STAMP_CAPTURE = 8'h30; // Capture arm and seen flag
  localparam logic [7:0] IDX_STAMP_VALUE   = 8'h31; // Captured time value

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_PIN1_CODE   = 8;  // Pin 1 code in the shared word
  localparam int POS_SLEEP_LEVEL = 8;  // Sleep level of slot outputs
  localparam int POS_EDGE_INVERT = 7;  // Stamp edge: 0 rising, 1 falling
  localparam int POS_STAMP_KEEP  = 6;  // Keep capture armed after a hit
  localparam int POS_STAMP_PIN   = 4;  // Stamp pin select, two bits
  localparam int POS_PACE_ENABLE = 2;  // Outside pacing enable
  localparam int POS_PACE_PIN    = 0;  // Outside pacing pin, two bits
  localparam int POS_CAPT_ARM    = 0;  // Capture armed
  localparam int POS_CAPT_SEEN   = 1;  // Capture happened, write one to clear

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_PIN01 = 16'h0000;
  localparam logic [7:0]  RST_PIN2  = 8'h00;
  localparam logic [8:0]  RST_CTRL  = 9'h000;

  // ****************************************
  // Route codes
  // ****************************************
  localparam logic [7:0] CODE_LOW      = 8'h00; // Constant low
  localparam logic [7:0] CODE_HIGH     = 8'h01; // Constant high
  localparam logic [7:0] CODE_MOD_A    = 8'h40; // First slot modulation pulse
  localparam logic [7:0] CODE_MOD_L    = 8'h4b; // Last slot modulation pulse
  localparam logic [7:0] CODE_MOD_ANY  = 8'h4f; // Active slot modulation pulse
  localparam logic [7:0] CODE_DC_A     = 8'h50; // Data cycle, slot A
  localparam logic [7:0] CODE_DC_J     = 8'h59; // Data cycle, slot J
  localparam logic [7:0] CODE_DC_ANY   = 8'h5a; // Data cycle, any slot
  localparam logic [7:0] CODE_DC_K     = 8'h5b; // Data cycle, slot K
  localparam logic [7:0] CODE_DC_L     = 8'h5f; // Data cycle, slot L

  // Pin select values for stamp and pacing
  localparam logic [1:0] SEL_PIN0 = 2'h0;
  localparam logic [1:0] SEL_PIN1 = 2'h1;
  localparam logic [1:0] SEL_PIN2 = 2'h2;

  // Read phase states
  typedef enum logic [1:0] {
    GSR_RD_IDLE = 2'b01,
    GSR_RD_WAIT = 2'b10
  } gsr_rd_state_t;

endpackage

// [core/gsr_pin_if.sv]
`timescale 1ns/1ps
// Synchronised pin levels and edges from the pin front end to the core
interface gsr_pin_if;
  logic [3:0] level; // Synchronised level of every pin
  logic [2:0] rise;  // One-cycle rising edge, pins 0 to 2
  logic [2:0] fall;  // One-cycle falling edge, pins 0 to 2
  modport front (output level, rise, fall);
  modport core  (input level, rise, fall);
endinterface

// [core/gsr_pin_sync.sv]
`timescale 1ns/1ps
module gsr_pin_sync
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] pin_in,
  gsr_pin_if.front        pins
);

  // ****************************************
  // Synchroniser and edge detector
  // ****************************************
  logic [3:0] stage1; // First stage, read only by stage2
  logic [3:0] stage2; // Stable level
  logic [2:0] stage3; // Previous level for edges

  // Two-flop synchroniser then one delay for edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
      stage3 <= 3'h0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2[2:0];
    end
  end

  assign pins.level = stage2;
  assign pins.rise  = stage2[2:0] & ~stage3;
  assign pins.fall  = ~stage2[2:0] & stage3;

endmodule // gsr_pin_sync

// [core/gsr_core.sv]
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module gsr_core
#(
  parameter int NUM_SLOTS = 12, // Time slots A to L
  parameter int STAMP_W   = 16  // Width of the time base
)
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NUM_SLOTS-1:0] slot_mod_pulse,
  input  wire logic [NUM_SLOTS-1:0] slot_data_cycle,
  input  wire logic                 slot_asleep,
  input  wire logic                 period_tick,
  input  wire logic [3:0]           pin_in,
  input  wire logic [3:0]           pin_in_enable,
  output logic      [2:0]           pin_out,
  output logic                      sample_start
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_SLOTS != 12) $error("NUM_SLOTS must be 12");
  if (STAMP_W < 1 || STAMP_W > 32) $error("STAMP_W must be 1 to 32");

  // ****************************************
  // Declarations
  // ****************************************
  gsr_pin_if              pins ();        // Synchronised pin levels and edges
  logic [15:0]            pin01_route;    // Pin 1 code high, pin 0 code low
  logic [7:0]             pin2_route;     // Pin 2 code
  logic [8:0]             ctrl;           // Stamp and sync control bits
  logic                   capt_arm;       // Stamp capture armed
  logic                   capt_seen;      // A capture has happened
  logic [STAMP_W-1:0]     time_base;      // Free-running time base
  logic [STAMP_W-1:0]     stamp_value;    // Time of last capture
  logic [7:0]             dp_index;       // Register index of data phase
  logic                   dp_write;       // Write data phase pending
  logic                   dp_read;        // Read data phase pending
  gsr_pkg::gsr_rd_state_t rd_state;       // Read wait state tracker
  logic                   addr_ok;        // Address phase accepted
  logic                   wr_en;          // Write strobe this cycle
  logic                   stamp_edge;     // Qualifying stamp edge
  logic                   pace_edge;      // Rising edge on pacing pin
  logic [2:0]             next_pin_out;   // Next pin drive values

  // Picks one of pins 0 to 2; value 3 selects nothing
  function automatic logic pick_pin(input logic [2:0] v, input logic [1:0] sel);
    case (sel)
      gsr_pkg::SEL_PIN0: pick_pin = v[0];
      gsr_pkg::SEL_PIN1: pick_pin = v[1];
      gsr_pkg::SEL_PIN2: pick_pin = v[2];
      default:           pick_pin = 1'b0;
    endcase
  endfunction

  // Decodes one route code into a pin level
  function automatic logic route(input logic [7:0] code, input logic [11:0] mod,
                                 input logic [11:0] dc, input logic asleep,
                                 input logic sleep_lvl);
    logic slot_bit;
    logic slot_spec;
    slot_bit  = 1'b0;
    slot_spec = 1'b1;
    if (code >= gsr_pkg::CODE_MOD_A && code <= gsr_pkg::CODE_MOD_L)
      slot_bit = mod[code[3:0]];
    else if (code == gsr_pkg::CODE_MOD_ANY)
      slot_bit = |mod;
    else if (code >= gsr_pkg::CODE_DC_A && code <= gsr_pkg::CODE_DC_J)
      slot_bit = dc[code[3:0]];
    else if (code == gsr_pkg::CODE_DC_ANY)
      slot_bit = |dc;
    else if (code == gsr_pkg::CODE_DC_K)
      slot_bit = dc[10];
    else if (code == gsr_pkg::CODE_DC_L)
      slot_bit = dc[11];
    else
      slot_spec = 1'b0;
    if (slot_spec)
      route = asleep ? sleep_lvl : slot_bit;
    else
      route = (code == gsr_pkg::CODE_HIGH);
  endfunction

  // ****************************************
  // Pin front end
  // ****************************************
  gsr_pin_sync u_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (pin_in),
    .pins    (pins.front)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  assign addr_ok   = hsel && htrans[1] && hready;
  assign wr_en     = dp_write;
  assign hresp     = 1'b0;
  assign hreadyout = !(dp_read && rd_state == gsr_pkg::GSR_RD_IDLE);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_index <= 8'h00;
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
    end
    else if (hreadyout)
    begin
      dp_index <= haddr[9:2];
      dp_write <= addr_ok && hwrite;
      dp_read  <= addr_ok && !hwrite;
    end
  end

  // Read wait state: data is registered one cycle into the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_state <= gsr_pkg::GSR_RD_IDLE;
    else
      case (rd_state)
        gsr_pkg::GSR_RD_IDLE: if (dp_read) rd_state <= gsr_pkg::GSR_RD_WAIT;
        gsr_pkg::GSR_RD_WAIT: rd_state <= gsr_pkg::GSR_RD_IDLE;
        default:              rd_state <= gsr_pkg::GSR_RD_IDLE;
      endcase
  end

  // Read data mux; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (dp_read && rd_state == gsr_pkg::GSR_RD_IDLE)
      case (dp_index)
        gsr_pkg::IDX_PIN01_ROUTE:   hrdata <= {16'h0000, pin01_route};
        gsr_pkg::IDX_PIN2_ROUTE:    hrdata <= {24'h000000, pin2_route};
        gsr_pkg::IDX_INPUT_LEVELS:
          hrdata <= {28'h0000000, pins.level & pin_in_enable};
        gsr_pkg::IDX_STAMP_SYNC:    hrdata <= {23'h000000, ctrl};
        gsr_pkg::IDX_STAMP_CAPTURE: hrdata <= {30'h00000000, capt_seen, capt_arm};
        gsr_pkg::IDX_STAMP_VALUE:   hrdata <= 32'(stamp_value);
        default:                    hrdata <= 32'h0000_0000;
      endcase
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Route codes and control bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin01_route <= gsr_pkg::RST_PIN01;
      pin2_route  <= gsr_pkg::RST_PIN2;
      ctrl        <= gsr_pkg::RST_CTRL;
    end
    else if (wr_en)
      case (dp_index)
        gsr_pkg::IDX_PIN01_ROUTE: pin01_route <= hwdata[15:0];
        gsr_pkg::IDX_PIN2_ROUTE:  pin2_route  <= hwdata[7:0];
        gsr_pkg::IDX_STAMP_SYNC:  ctrl <= {hwdata[8:4], 1'b0, hwdata[2:0]};
        default:                  ;
      endcase
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_comb
  begin
    next_pin_out[0] = route(pin01_route[7:0], slot_mod_pulse, slot_data_cycle,
                            slot_asleep, ctrl[gsr_pkg::POS_SLEEP_LEVEL]);
    next_pin_out[1] = route(pin01_route[15:8], slot_mod_pulse, slot_data_cycle,
                            slot_asleep, ctrl[gsr_pkg::POS_SLEEP_LEVEL]);
    next_pin_out[2] = route(pin2_route, slot_mod_pulse, slot_data_cycle,
                            slot_asleep, ctrl[gsr_pkg::POS_SLEEP_LEVEL]);
  end

  // Registered pin outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_out <= 3'h0;
    else
      pin_out <= next_pin_out;
  end

  // ****************************************
  // Time stamp capture
  // ****************************************
  assign stamp_edge = pick_pin(ctrl[gsr_pkg::POS_EDGE_INVERT] ? pins.fall : pins.rise,
                               ctrl[gsr_pkg::POS_STAMP_PIN +: 2]);

  // Free-running time base
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      time_base <= '0;
    else
      time_base <= time_base + 1'b1;
  end

  // Arm, seen flag and captured value; a hit beats a clearing write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capt_arm    <= 1'b0;
      capt_seen   <= 1'b0;
      stamp_value <= '0;
    end
    else
    begin
      if (wr_en && dp_index == gsr_pkg::IDX_STAMP_CAPTURE)
      begin
        capt_arm <= hwdata[gsr_pkg::POS_CAPT_ARM];
        if (hwdata[gsr_pkg::POS_CAPT_SEEN])
          capt_seen <= 1'b0;
      end
      else if (capt_arm && stamp_edge && !ctrl[gsr_pkg::POS_STAMP_KEEP])
        capt_arm <= 1'b0;
      if (capt_arm && stamp_edge)
      begin
        stamp_value <= time_base;
        capt_seen   <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sample pacing
  // ****************************************
  assign pace_edge = pick_pin(pins.rise, ctrl[gsr_pkg::POS_PACE_PIN +: 2]);

  // Sample start comes from the pin or from the period counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sample_start <= 1'b0;
    else if (ctrl[gsr_pkg::POS_PACE_ENABLE])
      sample_start <= pace_edge;
    else
      sample_start <= period_tick;
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_MOD_B: assert property (@(posedge hclk) disable iff (!hresetn)
    pin01_route[15:8] == 8'h41 && !slot_asleep |=> pin_out[1] == $past(slot_mod_pulse[1]))
    else $error("pin 1 not following slot B modulation");

  AST_MOD_ANY: assert property (@(posedge hclk) disable iff (!hresetn)
    pin2_route == 8'h4f && !slot_asleep |=> pin_out[2] == $past(|slot_mod_pulse))
    else $error("pin 2 not following active slot modulation");

  AST_DC_L: assert property (@(posedge hclk) disable iff (!hresetn)
    pin2_route == 8'h5f && !slot_asleep |=> pin_out[2] == $past(slot_data_cycle[11]))
    else $error("pin 2 not following slot L data cycle");

  AST_DC_ANY: assert property (@(posedge hclk) disable iff (!hresetn)
    pin01_route[7:0] == 8'h5a && !slot_asleep |=> pin_out[0] == $past(|slot_data_cycle))
    else $error("pin 0 not following any slot data cycle");

  AST_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    pin2_route == 8'h41 && slot_asleep |=> pin_out[2] == $past(ctrl[8]))
    else $error("sleep level not driven");

  AST_DISARM: assert property (@(posedge hclk) disable iff (!hresetn)
    capt_arm && stamp_edge && !ctrl[6] && !wr_en |=> !capt_arm && capt_seen)
    else $error("capture did not disarm");

  AST_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    capt_arm && stamp_edge && ctrl[6] && !wr_en |=> capt_arm ##1 capt_arm || !stamp_edge)
    else $error("capture disarmed while kept");

  AST_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl[7] && ctrl[5:4] == 2'h1 && capt_arm && $fell(pins.level[1]) |-> stamp_edge)
    else $error("falling edge on pin 1 not taken");

  AST_PACE: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl[2] && ctrl[1:0] == 2'h2 && $rose(pins.level[2]) |=> sample_start)
    else $error("pacing edge on pin 2 lost");

  AST_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[2] |=> sample_start == $past(period_tick))
    else $error("period tick not passed");

  AST_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_read && !hreadyout |=> hreadyout [*1])
    else $error("read wait longer than one cycle");

  COV_CAPTURE: cover property (@(posedge hclk) disable iff (!hresetn)
    capt_arm && stamp_edge);
  COV_PACE: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl[2] && pace_edge ##1 sample_start);
  COV_READ: cover property (@(posedge hclk) disable iff (!hresetn)
    dp_read ##1 hreadyout);

endmodule // gsr_core

// [tb/gsr_pin_partner.sv]
`timescale 1ns/1ps
// ****************************************
// Far-side logic on the general-purpose pins
// ****************************************
module gsr_pin_partner
(
  input  wire logic       hclk,
  input  wire logic [2:0] pin_out,
  output logic      [3:0] pin_in
);
  logic [3:0] lvl = 4'h0; // Level held on pins 0 to 3
  logic [2:0] seen_out;   // Route outputs seen last cycle, compared by route_chk

  // Pins are always driven by this party, so no line floats
  assign pin_in = lvl;

  // Keep a copy of what the block drives back
  always_ff @(posedge hclk)
  begin
    seen_out <= pin_out;
  end

  // Present a new level; the caller paces sync edges at its sample rate
  task automatic drive(input logic [3:0] v);
    lvl <= v;
  endtask
endmodule // gsr_pin_partner

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        hclk = 1'b0;              // Bus clock, 10 MHz
  logic        hresetn = 1'b0;           // Reset, active low
  logic        hsel = 1'b0;              // Slave select
  logic [31:0] haddr = 32'h0;            // Byte address
  logic [1:0]  htrans = 2'h0;            // Transfer type
  logic        hwrite = 1'b0;            // Write flag
  logic [2:0]  hsize = 3'h2;             // Word transfers only
  logic [31:0] hwdata = 32'h0;           // Write data
  logic [31:0] hrdata;                   // Read data
  logic        hreadyout;                // Slave ready, also bus ready
  logic        hresp;                    // Response
  logic [11:0] slot_mod_pulse = 12'h0;   // Slot modulation pulses
  logic [11:0] slot_data_cycle = 12'h0;  // Slot data cycle markers
  logic        slot_asleep = 1'b0;       // Slot logic asleep
  logic        period_tick = 1'b0;       // Internal period pulse
  logic [3:0]  pin_in;                   // Pin levels from the partner
  logic [3:0]  pin_in_enable = 4'hf;     // Input buffers on
  logic [2:0]  pin_out;                  // Routed pin drive
  logic        sample_start;             // Sample start pulse
  int          n_errors = 0;             // Mismatches
  int          n_tests = 0;              // Comparisons
  int          n_cycles = 0;             // Watchdog count
  int          n_starts = 0;             // Sample starts seen
  int          base;                     // Start count before a stimulus
  logic [11:0] oh;                       // One-hot slot pattern
  logic [7:0]  code;                     // Route code under test
  logic [31:0] stamp1;                   // First kept capture value

  // Clock of 100 ns period
  always #50 hclk = ~hclk;

  // ****************************************
  // Design and partner
  // ****************************************
  gsr_core gsr_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slot_mod_pulse(slot_mod_pulse),
    .slot_data_cycle(slot_data_cycle), .slot_asleep(slot_asleep), .period_tick(period_tick),
    .pin_in(pin_in), .pin_in_enable(pin_in_enable), .pin_out(pin_out),
    .sample_start(sample_start));
  gsr_pin_partner gsr_pin_partner_i (.hclk(hclk), .pin_out(pin_out), .pin_in(pin_in));

  // Count sample starts and cut a hang short
  always @(posedge hclk)
  begin
    if (sample_start === 1'b1)
      n_starts++;
    n_cycles++;
    if (n_cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Wait for a rising edge that sees the bus ready
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask

  task automatic ahb_write(input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic ahb_read(input logic [7:0] idx, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask

  // Compare a word and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read a register and compare it
  task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    ahb_read(idx, d);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Set a route code on one pin, drive the slots, compare the pin
  task automatic route_chk(input int p, input logic [7:0] c, input logic [11:0] m,
                           input logic [11:0] dc, input logic e);
    if (p == 2)
      ahb_write(gsr_pkg::IDX_PIN2_ROUTE, {24'h0, c});
    else
      ahb_write(gsr_pkg::IDX_PIN01_ROUTE, {16'h0, c} << (8 * p));
    slot_mod_pulse <= m;
    slot_data_cycle <= dc;
    tick(3);
    chk({31'h0, pin_out[p]}, {31'h0, e});
    chk({31'h0, gsr_pin_partner_i.seen_out[p]}, {31'h0, e});
  endtask

  // Pin rises, then falls; count sample starts
  task automatic pace_chk(input int n, input int exp);
    gsr_pin_partner_i.drive(4'h0);
    tick(6);
    base = n_starts;
    gsr_pin_partner_i.drive(4'h1 << n);
    tick(8);
    gsr_pin_partner_i.drive(4'h0);
    tick(8);
    chk(n_starts - base, exp);
  endtask

  task automatic summarize();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    tick(10);
    hresetn <= 1'b1;
    tick(1);
    // Reset values and access kinds
    chk_rd(gsr_pkg::IDX_PIN01_ROUTE, 32'h0);
    chk_rd(gsr_pkg::IDX_PIN2_ROUTE, 32'h0);
    chk_rd(gsr_pkg::IDX_STAMP_SYNC, 32'h0);
    chk_rd(gsr_pkg::IDX_INPUT_LEVELS, 32'h0);
    chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h0);
    chk_rd(gsr_pkg::IDX_STAMP_VALUE, 32'h0);
    ahb_write(gsr_pkg::IDX_PIN01_ROUTE, 32'hffffffff);
    chk_rd(gsr_pkg::IDX_PIN01_ROUTE, 32'h0000ffff);
    ahb_write(gsr_pkg::IDX_PIN2_ROUTE, 32'hffffffff);
    chk_rd(gsr_pkg::IDX_PIN2_ROUTE, 32'h000000ff);
    ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'hffffffff);
    chk_rd(gsr_pkg::IDX_STAMP_SYNC, 32'h000001f7);
    chk_rd(8'h10, 32'h0);
    // Input levels masked by buffer enables, read-only
    gsr_pin_partner_i.drive(4'ha);
    pin_in_enable <= 4'h6;
    ahb_write(gsr_pkg::IDX_INPUT_LEVELS, 32'hffffffff);
    chk_rd(gsr_pkg::IDX_INPUT_LEVELS, 32'h2);
    pin_in_enable <= 4'hf;
    tick(1);
    chk_rd(gsr_pkg::IDX_INPUT_LEVELS, 32'ha);
    ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h0);
    // Per-slot codes, slot k on pin k % 3, with the other slot group as distraction
    for (int k = 0; k < 12; k++)
    begin
      oh = 12'h1 << k;
      code = (k < 10) ? 8'h50 + k[7:0] : ((k == 10) ? 8'h5b : 8'h5f);
      route_chk(k % 3, 8'h40 + k[7:0], oh, ~oh, 1'b1);
      route_chk(k % 3, 8'h40 + k[7:0], ~oh, oh, 1'b0);
      route_chk(k % 3, code, ~oh, oh, 1'b1);
      route_chk(k % 3, code, oh, ~oh, 1'b0);
      route_chk(k % 3, 8'h4f, oh, 12'h0, 1'b1);
      route_chk(k % 3, 8'h5a, 12'h0, oh, 1'b1);
      route_chk(k % 3, 8'h5a, 12'hfff, 12'h0, 1'b0);
    end
    // Constant and unlisted codes ignore the slots
    route_chk(0, 8'h01, 12'h0, 12'h0, 1'b1);
    route_chk(1, 8'h00, 12'hfff, 12'hfff, 1'b0);
    route_chk(2, 8'h4c, 12'hfff, 12'hfff, 1'b0);
    // Slot outputs hold the sleep level while asleep
    slot_asleep <= 1'b1;
    ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h100);
    route_chk(0, 8'h41, 12'h0, 12'h0, 1'b1);
    ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h0);
    route_chk(2, 8'h41, 12'hfff, 12'h0, 1'b0);
    route_chk(1, 8'h01, 12'h0, 12'h0, 1'b1);
    slot_asleep <= 1'b0;
    // Outside pacing on each pin; period counter then ignored
    for (int n = 0; n < 3; n++)
    begin
      ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h4 | n);
      pace_chk(n, 1);
      pace_chk((n + 1) % 3, 0);
    end
    base = n_starts;
    period_tick <= 1'b1;
    tick(1);
    period_tick <= 1'b0;
    tick(4);
    chk(n_starts - base, 0);
    ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h0);
    base = n_starts;
    period_tick <= 1'b1;
    tick(1);
    period_tick <= 1'b0;
    tick(4);
    chk(n_starts - base, 1);
    pace_chk(0, 0);
    // Time stamp source, edge and keep-armed on each pin
    for (int n = 0; n < 3; n++)
    begin
      ahb_write(gsr_pkg::IDX_STAMP_SYNC, n << 4);
      ahb_write(gsr_pkg::IDX_STAMP_CAPTURE, 32'h3);
      pace_chk((n + 1) % 3, 0);
      chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h1);
      pace_chk(n, 0);
      chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h2);
      ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h40 | (n << 4));
      ahb_write(gsr_pkg::IDX_STAMP_CAPTURE, 32'h3);
      pace_chk(n, 0);
      chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h3);
      // Second kept capture lands 28 cycles after the first
      ahb_read(gsr_pkg::IDX_STAMP_VALUE, stamp1);
      pace_chk(n, 0);
      chk_rd(gsr_pkg::IDX_STAMP_VALUE, stamp1 + 32'd28);
      ahb_write(gsr_pkg::IDX_STAMP_SYNC, 32'h80 | (n << 4));
      ahb_write(gsr_pkg::IDX_STAMP_CAPTURE, 32'h3);
      gsr_pin_partner_i.drive(4'h1 << n);
      tick(8);
      chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h1);
      gsr_pin_partner_i.drive(4'h0);
      tick(8);
      chk_rd(gsr_pkg::IDX_STAMP_CAPTURE, 32'h2);
    end
    summarize();
  end
endmodule // tb_top
